// *** dv/tb_cafc_top.sv ***
`timescale 1ns/100ps
module tb_cafc_top;
  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  logic MCLK, RESET, REG_WR, PWM_SYNC; // clock, reset, strobes
  logic [6:0] REG_ADDR; // register index
  logic [31:0] REG_WDATA, REG_RDATA; // register data
  logic [15:0] DELTASIGMA_CHANNEL0_VALUE, DELTASIGMA_CHANNEL1_VALUE;
  logic MOD_CLK_A, MOD_CLK_B, DEC_STROBE_A, DEC_STROBE_B;
  logic [15:0] DECIMATION_RATE_A, DECIMATION_RATE_B;
  logic [15:0] RAW_CURRENT_ZERO, RAW_CURRENT_ONE;
  // kept unsigned here so the compare task zero-extends like its expectations
  logic [15:0] PHASE_U_CURRENT, PHASE_V_CURRENT, PHASE_W_CURRENT;
  int err_total, n_tests, cyc; // counters
  int ra, rb, sa, sb; // edge and strobe counts of one window
  logic [31:0] rd; // last read word

  cafc_top cafc_top_i (.MCLK(MCLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .PWM_SYNC(PWM_SYNC),
    .DELTASIGMA_CHANNEL0_VALUE(DELTASIGMA_CHANNEL0_VALUE),
    .DELTASIGMA_CHANNEL1_VALUE(DELTASIGMA_CHANNEL1_VALUE),
    .MOD_CLK_A(MOD_CLK_A), .MOD_CLK_B(MOD_CLK_B),
    .DECIMATION_RATE_A(DECIMATION_RATE_A),
    .DECIMATION_RATE_B(DECIMATION_RATE_B),
    .DEC_STROBE_A(DEC_STROBE_A), .DEC_STROBE_B(DEC_STROBE_B),
    .RAW_CURRENT_ZERO(RAW_CURRENT_ZERO), .RAW_CURRENT_ONE(RAW_CURRENT_ONE),
    .PHASE_U_CURRENT(PHASE_U_CURRENT), .PHASE_V_CURRENT(PHASE_V_CURRENT),
    .PHASE_W_CURRENT(PHASE_W_CURRENT));

  // ----------------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------------
  // 40 MHz core clock
  always #12.5 MCLK = ~MCLK;
  // whole run needs well under 2000 cycles
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  // compare and count; x never matches
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask
  // read data is registered, so allow two edges
  task automatic rdr(input logic [6:0] a);
    @(posedge MCLK);
    REG_ADDR <= a;
    repeat (2) @(posedge MCLK);
    #1 rd = REG_RDATA;
  endtask
  // count modulator clock rises and strobes over n edges
  task automatic count(input int n);
    logic pa, pb;
    ra = 0; rb = 0; sa = 0; sb = 0;
    @(posedge MCLK);
    #1 pa = MOD_CLK_A;
    pb = MOD_CLK_B;
    repeat (n) begin
      @(posedge MCLK);
      #1 ra += (MOD_CLK_A && !pa);
      rb += (MOD_CLK_B && !pb);
      sa += DEC_STROBE_A;
      sb += DEC_STROBE_B;
      pa = MOD_CLK_A;
      pb = MOD_CLK_B;
    end
  endtask
  // reference calibration, saturated to 16-bit signed
  function automatic logic [15:0] cal(input int raw, off, g);
    int v;
    v = ((raw - off) * g) >>> 8;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // reset values, readback of every register, unmapped place
  task automatic t_regs();
    logic [31:0] rv [7];
    rv = '{cafc_pkg::INCR_RESET, cafc_pkg::INCR_RESET, cafc_pkg::DEC_RESET,
      cafc_pkg::CAL_RESET, cafc_pkg::CAL_RESET, cafc_pkg::SEL_RESET,
      cafc_pkg::EXT_RESET};
    for (int i = 0; i < 7; i++) begin
      rdr(7'h05 + 7'(i));
      chk(rd, rv[i], "reset value");
    end
    for (int i = 0; i < 7; i++) wr(7'h05 + 7'(i), 32'hA5C3_0F10 + i);
    for (int i = 0; i < 7; i++) begin
      rdr(7'h05 + 7'(i));
      chk(rd, 32'hA5C3_0F10 + i, "readback");
    end
    wr(7'h0C, 32'hFFFF_FFFF);
    rdr(7'h0C);
    chk(rd, 32'h0000_0000, "unmapped read");
  endtask
  // modulator clock rate and decimation strobes
  task automatic t_nco();
    wr(cafc_pkg::ADDR_INCR_A, 32'h2000_0000);
    wr(cafc_pkg::ADDR_INCR_B, 32'h1000_0000);
    wr(cafc_pkg::ADDR_DEC, 32'h0002_0000);
    count(64);
    chk(ra, 16, "mod clk a quarter rate");
    chk(rb, 8, "mod clk b eighth rate");
    chk(sb, 4, "rate b every 2nd rise");
    chk(sa, 0, "rate a idle without sync");
    chk({DECIMATION_RATE_B, DECIMATION_RATE_A}, 32'h0002_0000, "rates");
    wr(cafc_pkg::ADDR_INCR_A, 32'h4000_0000);
    wr(cafc_pkg::ADDR_INCR_B, 32'h4000_0000);
    count(64);
    chk(ra, 32, "mod clk a half rate");
    chk(rb, 32, "mod clk b half rate");
    @(posedge MCLK);
    PWM_SYNC <= 1'b1;
    @(posedge MCLK);
    PWM_SYNC <= 1'b0;
    #1 chk(DEC_STROBE_A, 1'b1, "sync strobe a");
    @(posedge MCLK);
    #1 chk(DEC_STROBE_A, 1'b0, "strobe one cycle");
  endtask
  // raw source codes for both raw currents, out-of-range code
  task automatic t_src();
    logic [15:0] e;
    wr(cafc_pkg::ADDR_EXT, 32'h3333_2222);
    for (int c = 0; c < 5; c++) begin
      wr(cafc_pkg::ADDR_SEL, 32'h2400_0000 | (c << 8) | c);
      repeat (3) @(posedge MCLK);
      e = c == 1 ? 16'h0800 : c == 2 ? 16'h2222 : c == 3 ? 16'h3333 : 16'h1000;
      #1 chk(RAW_CURRENT_ZERO, e, "raw current 0 source");
      chk(RAW_CURRENT_ONE, e, "raw current 1 source");
    end
  endtask
  // calibration, sum, saturation and phase mapping
  task automatic t_cal();
    logic [15:0] c0, c1;
    wr(cafc_pkg::ADDR_SEL, cafc_pkg::SEL_RESET);
    wr(cafc_pkg::ADDR_CAL0, 32'h0200_0100);
    wr(cafc_pkg::ADDR_CAL1, 32'h0180_0000);
    repeat (5) @(posedge MCLK);
    c0 = cal(32'h1000, 32'h0100, 32'h0200);
    c1 = cal(32'h0800, 0, 32'h0180);
    #1 chk(PHASE_U_CURRENT, c0, "phase u cal 0");
    chk(PHASE_V_CURRENT, c1, "phase v cal 1");
    chk(PHASE_W_CURRENT, 16'hD600, "phase w sum");
    wr(cafc_pkg::ADDR_SEL, 32'h0900_0100);
    repeat (5) @(posedge MCLK);
    #1 chk(PHASE_U_CURRENT, c1, "ux selects 1");
    chk(PHASE_V_CURRENT, 16'hD600, "v selects sum");
    chk(PHASE_W_CURRENT, c0, "wy selects 0");
    wr(cafc_pkg::ADDR_SEL, cafc_pkg::SEL_RESET);
    wr(cafc_pkg::ADDR_CAL0, 32'h7FFF_0000);
    repeat (5) @(posedge MCLK);
    #1 chk(PHASE_U_CURRENT, 16'h7FFF, "positive saturation");
    chk(PHASE_W_CURRENT, 16'h8000, "sum saturation");
  endtask

  // ----------------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    MCLK = 0; RESET = 1; REG_WR = 0; PWM_SYNC = 0; REG_ADDR = 0;
    REG_WDATA = 0; cyc = 0; err_total = 0; n_tests = 0;
    DELTASIGMA_CHANNEL0_VALUE = 16'h1000;
    DELTASIGMA_CHANNEL1_VALUE = 16'h0800;
    repeat (6) @(posedge MCLK);
    RESET <= 1'b0;
    t_regs();
    wr(cafc_pkg::ADDR_CAL0, cafc_pkg::CAL_RESET);
    wr(cafc_pkg::ADDR_CAL1, cafc_pkg::CAL_RESET);
    t_nco();
    // back to the standard increments, then left alone for the rest
    wr(cafc_pkg::ADDR_INCR_A, cafc_pkg::INCR_RESET);
    wr(cafc_pkg::ADDR_INCR_B, cafc_pkg::INCR_RESET);
    t_src();
    t_cal();
    finish_test();
  end
endmodule

// *** include/cafc_cal_if.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// carrier between the selector and one calibration stage
// ----------------------------------------------------------------------
interface cafc_cal_if;
  logic [15:0] raw;           // selected raw current
  logic [15:0] offset;        // unsigned offset
  logic signed [15:0] gain;   // signed q8 scale
  logic signed [15:0] result; // calibrated, saturated current
  modport calc (input raw, input offset, input gain, output result);
  modport user (output raw, output offset, output gain, input result);
endinterface

// *** include/cafc_pkg.sv ***
// ----------------------------------------------------------------------
// current front end configuration constants
// ----------------------------------------------------------------------
package cafc_pkg;

  // ----------------------------------------------------------------------
  // register indices on the register port
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_INCR_A = 7'h05; // modulator clock incr a
  localparam logic [6:0] ADDR_INCR_B = 7'h06; // modulator clock incr b
  localparam logic [6:0] ADDR_DEC = 7'h07;    // decimation rates
  localparam logic [6:0] ADDR_CAL1 = 7'h08;   // current1 calibration
  localparam logic [6:0] ADDR_CAL0 = 7'h09;   // current0 calibration
  localparam logic [6:0] ADDR_SEL = 7'h0A;    // current source select
  localparam logic [6:0] ADDR_EXT = 7'h0B;    // external current values

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int HALF_W = 16;      // width of offset, gain, rate fields
  localparam int SEL_W = 8;        // width of a raw source select
  localparam int PH_W = 2;         // width of a phase select
  localparam int UX_LSB = 24;      // phase u select position
  localparam int V_LSB = 26;       // phase v select position
  localparam int WY_LSB = 28;      // phase w select position
  localparam int NCO_W = 31;       // accumulator width, wraps at 2^31
  localparam int GAIN_SHIFT = 8;   // gain is signed q8: 0x0100 is unity

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] INCR_RESET = 32'h2000_0000; // quarter of clk
  localparam logic [31:0] DEC_RESET = 32'h0000_0000;  // pwm synchronous
  localparam logic [31:0] CAL_RESET = 32'h0100_0000;  // unity, no offset
  localparam logic [31:0] SEL_RESET = 32'h2400_0100;  // ux=0 v=1 wy=2
  localparam logic [31:0] EXT_RESET = 32'h0000_0000;  // no ext values

  // ----------------------------------------------------------------------
  // source and phase codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] SRC_DS0 = 8'h00;  // delta-sigma channel 0
  localparam logic [7:0] SRC_DS1 = 8'h01;  // delta-sigma channel 1
  localparam logic [7:0] SRC_EXT0 = 8'h02; // external value 0
  localparam logic [7:0] SRC_EXT1 = 8'h03; // external value 1
  localparam logic [1:0] PH_I0 = 2'h0;     // calibrated current 0
  localparam logic [1:0] PH_I1 = 2'h1;     // calibrated current 1
  localparam logic [1:0] PH_I2 = 2'h2;     // current sum

  // ----------------------------------------------------------------------
  // saturation limits
  // ----------------------------------------------------------------------
  localparam logic signed [15:0] CUR_MAX = 16'sh7FFF;
  localparam logic signed [15:0] CUR_MIN = 16'sh8000;

endpackage

// *** verilog/cafc_calib.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// offset and gain correction for one current channel
// ----------------------------------------------------------------------
module cafc_calib (
  input wire logic clk,
  input wire logic reset,
  cafc_cal_if.calc bus
);
  logic signed [16:0] diff;          // raw minus offset
  logic signed [32:0] prod;          // diff times gain
  logic signed [32:0] scaled;        // back to current units
  logic signed [15:0] next_result;   // saturated value

  // subtract, scale, clamp; the 33-bit product cannot overflow
  always_comb begin
    diff = $signed({1'b0, bus.raw}) - $signed({1'b0, bus.offset}); // RQ12
    prod = diff * bus.gain;
    scaled = prod >>> cafc_pkg::GAIN_SHIFT;
    if (scaled > cafc_pkg::CUR_MAX) begin
      next_result = cafc_pkg::CUR_MAX; // RQ12
    end else if (scaled < cafc_pkg::CUR_MIN) begin
      next_result = cafc_pkg::CUR_MIN; // RQ12
    end else begin
      next_result = scaled[15:0];
    end
  end

  // one register stage so the multiplier has a full cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      bus.result <= 16'sh0000;
    end else begin
      bus.result <= next_result;
    end
  end

  // unity gain passes the difference through unchanged
  a_cal_unity: assert property (@(posedge clk) disable iff (reset) // RQ12
    (bus.gain == 16'sh0100 && bus.raw >= bus.offset &&
     (bus.raw - bus.offset) <= 16'h7FFF)
    |=> bus.result == $past(bus.raw - bus.offset))
    else $error("unity gain result wrong");

  // a large positive product clamps at the top
  a_cal_clamp: assert property (@(posedge clk) disable iff (reset) // RQ12
    (bus.gain == 16'sh7FFF && bus.raw == 16'h1000 && bus.offset == 16'h0000)
    |=> bus.result == cafc_pkg::CUR_MAX)
    else $error("calibrated current not saturated");

endmodule

// *** verilog/cafc_top.sv ***
`timescale 1ns/100ps
// Summary of operation
// RQ1 - modulator clock is incr times clk over 2^31
// RQ2 - software leaves increments alone with internal modulators
// RQ3 - zero rate means pwm synchronous, else field value
// RQ4 - rates drive sinc3 decimation; software matches pwm
// RQ5 - current1 corrected by unsigned offset, signed gain
// RQ6 - current0 corrected by unsigned offset, signed gain
// RQ7 - raw current0 source: ds0, ds1, ext0, ext1
// RQ8 - loop currents take a converted value or sum
// RQ9 - raw current1 source at bits 15:8, same codes
// RQ10 - phase selects map ux, v, wy to currents
// RQ11 - software writes external values into low/high halves
// RQ12 - calibrated current is (raw-offset)*gain, saturated
module cafc_top (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [6:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  input wire logic PWM_SYNC,
  input wire logic [15:0] DELTASIGMA_CHANNEL0_VALUE,
  input wire logic [15:0] DELTASIGMA_CHANNEL1_VALUE,
  output logic MOD_CLK_A,
  output logic MOD_CLK_B,
  output logic [15:0] DECIMATION_RATE_A,
  output logic [15:0] DECIMATION_RATE_B,
  output logic DEC_STROBE_A,
  output logic DEC_STROBE_B,
  output logic [15:0] RAW_CURRENT_ZERO,
  output logic [15:0] RAW_CURRENT_ONE,
  output logic signed [15:0] PHASE_U_CURRENT,
  output logic signed [15:0] PHASE_V_CURRENT,
  output logic signed [15:0] PHASE_W_CURRENT
);

  // ----------------------------------------------------------------------
  // registers and internal state
  // ----------------------------------------------------------------------
  logic [31:0] incr [2];           // modulator clock increments a, b
  logic [31:0] decimation_rates;   // rate b high, rate a low
  logic [31:0] calib [2];          // index 0 current0, 1 current1
  logic [31:0] current_source_select; // raw and phase selects
  logic [31:0] external_value;     // ext current 1 high, 0 low
  logic [cafc_pkg::NCO_W-1:0] acc [2]; // phase accumulators
  logic msb_prev [2];              // last modulator clock level
  logic [15:0] dec_cnt [2];        // modulator edges since strobe
  logic dec_strobe [2];            // decimation strobe per channel
  logic [15:0] raw [2];            // selected raw currents
  logic signed [15:0] cur [2];     // calibrated currents
  logic signed [15:0] current_sum; // negated sum of both currents
  logic [31:0] next_rdata;         // read mux

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // raw source decode, shared by both raw currents
  function automatic logic [15:0] pick_source(
    input logic [7:0] code,
    input logic [15:0] ds0,
    input logic [15:0] ds1,
    input logic [15:0] ext0,
    input logic [15:0] ext1
  );
    logic [15:0] v;
    v = ds0; // undefined codes fall back to channel 0
    case (code)
      cafc_pkg::SRC_DS1: v = ds1;
      cafc_pkg::SRC_EXT0: v = ext0;
      cafc_pkg::SRC_EXT1: v = ext1;
      default: v = ds0;
    endcase
    return v;
  endfunction

  // phase decode, shared by the three phases; code 3 reads current 0
  function automatic logic signed [15:0] pick_phase(
    input logic [1:0] code,
    input logic signed [15:0] i0,
    input logic signed [15:0] i1,
    input logic signed [15:0] i2
  );
    logic signed [15:0] v;
    v = i0;
    case (code)
      cafc_pkg::PH_I1: v = i1;
      cafc_pkg::PH_I2: v = i2;
      default: v = i0;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  // writes to unmapped indices are dropped silently
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      incr[0] <= cafc_pkg::INCR_RESET;
      incr[1] <= cafc_pkg::INCR_RESET;
      decimation_rates <= cafc_pkg::DEC_RESET;
      calib[0] <= cafc_pkg::CAL_RESET;
      calib[1] <= cafc_pkg::CAL_RESET;
      current_source_select <= cafc_pkg::SEL_RESET;
      external_value <= cafc_pkg::EXT_RESET;
    end else if (REG_WR) begin
      case (REG_ADDR)
        cafc_pkg::ADDR_INCR_A: incr[0] <= REG_WDATA; // RQ1
        cafc_pkg::ADDR_INCR_B: incr[1] <= REG_WDATA; // RQ1
        cafc_pkg::ADDR_DEC: decimation_rates <= REG_WDATA; // RQ3
        cafc_pkg::ADDR_CAL1: calib[1] <= REG_WDATA; // RQ5
        cafc_pkg::ADDR_CAL0: calib[0] <= REG_WDATA; // RQ6
        cafc_pkg::ADDR_SEL: current_source_select <= REG_WDATA; // RQ7
        cafc_pkg::ADDR_EXT: external_value <= REG_WDATA;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------
  // read data follows the address one cycle later; unmapped reads zero
  always_comb begin
    case (REG_ADDR)
      cafc_pkg::ADDR_INCR_A: next_rdata = incr[0];
      cafc_pkg::ADDR_INCR_B: next_rdata = incr[1];
      cafc_pkg::ADDR_DEC: next_rdata = decimation_rates;
      cafc_pkg::ADDR_CAL1: next_rdata = calib[1];
      cafc_pkg::ADDR_CAL0: next_rdata = calib[0];
      cafc_pkg::ADDR_SEL: next_rdata = current_source_select;
      cafc_pkg::ADDR_EXT: next_rdata = external_value;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // registered read port
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      REG_RDATA <= 32'h0000_0000;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // per-channel clocking, decimation, selection and calibration
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : gen_chan
    logic [15:0] rate;             // this channel's decimation rate
    logic mod_rise;                // modulator clock rising this cycle
    cafc_cal_if cal_bus ();        // link to the calibration stage

    assign rate = decimation_rates[g*cafc_pkg::HALF_W +: cafc_pkg::HALF_W];
    assign mod_rise = acc[g][cafc_pkg::NCO_W-1] & ~msb_prev[g];

    // accumulator wraps at 2^31, so its msb runs at incr*f/2^31;
    // increments of 2^31 and above alias, which software must avoid
    always_ff @(posedge MCLK) begin
      if (RESET) begin
        acc[g] <= '0;
        msb_prev[g] <= 1'b0;
      end else begin
        acc[g] <= acc[g] + incr[g][cafc_pkg::NCO_W-1:0]; // RQ1
        msb_prev[g] <= acc[g][cafc_pkg::NCO_W-1];
      end
    end

    // zero rate follows pwm, else one strobe per rate modulator edges
    always_ff @(posedge MCLK) begin
      if (RESET) begin
        dec_cnt[g] <= 16'h0000;
        dec_strobe[g] <= 1'b0;
      end else if (rate == 16'h0000) begin
        dec_cnt[g] <= 16'h0000;
        dec_strobe[g] <= PWM_SYNC; // RQ3
      end else if (mod_rise) begin
        if (dec_cnt[g] >= rate - 16'h0001) begin
          dec_cnt[g] <= 16'h0000;
          dec_strobe[g] <= 1'b1; // RQ4
        end else begin
          dec_cnt[g] <= dec_cnt[g] + 16'h0001;
          dec_strobe[g] <= 1'b0;
        end
      end else begin
        dec_strobe[g] <= 1'b0;
      end
    end

    // raw source mux, registered before calibration
    always_ff @(posedge MCLK) begin
      if (RESET) begin
        raw[g] <= 16'h0000;
      end else begin
        raw[g] <= pick_source( // RQ7 RQ9
          current_source_select[g*cafc_pkg::SEL_W +: cafc_pkg::SEL_W],
          DELTASIGMA_CHANNEL0_VALUE, DELTASIGMA_CHANNEL1_VALUE,
          external_value[cafc_pkg::HALF_W-1:0],
          external_value[2*cafc_pkg::HALF_W-1:cafc_pkg::HALF_W]);
      end
    end

    // offset in the low half, signed gain in the high half
    assign cal_bus.raw = raw[g];
    assign cal_bus.offset = calib[g][cafc_pkg::HALF_W-1:0]; // RQ5 RQ6
    assign cal_bus.gain = calib[g][2*cafc_pkg::HALF_W-1:cafc_pkg::HALF_W];
    assign cur[g] = cal_bus.result;

    cafc_calib cafc_calib_i (
      .clk(MCLK),
      .reset(RESET),
      .bus(cal_bus.calc)
    );
  end

  // ----------------------------------------------------------------------
  // current sum and phase assignment
  // ----------------------------------------------------------------------
  // the third current is the negated sum, clamped like the others;
  // 18 bits so negating the most negative sum cannot wrap
  always_comb begin
    logic signed [17:0] s;
    s = 18'(cur[0]) + 18'(cur[1]);
    s = -s; // RQ8
    if (s > cafc_pkg::CUR_MAX) begin
      current_sum = cafc_pkg::CUR_MAX;
    end else if (s < cafc_pkg::CUR_MIN) begin
      current_sum = cafc_pkg::CUR_MIN;
    end else begin
      current_sum = s[15:0];
    end
  end

  // phase outputs pick a converted current or the sum
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PHASE_U_CURRENT <= 16'sh0000;
      PHASE_V_CURRENT <= 16'sh0000;
      PHASE_W_CURRENT <= 16'sh0000;
    end else begin
      PHASE_U_CURRENT <= pick_phase( // RQ10
        current_source_select[cafc_pkg::UX_LSB +: cafc_pkg::PH_W],
        cur[0], cur[1], current_sum);
      PHASE_V_CURRENT <= pick_phase( // RQ10
        current_source_select[cafc_pkg::V_LSB +: cafc_pkg::PH_W],
        cur[0], cur[1], current_sum);
      PHASE_W_CURRENT <= pick_phase( // RQ10
        current_source_select[cafc_pkg::WY_LSB +: cafc_pkg::PH_W],
        cur[0], cur[1], current_sum);
    end
  end

  // ----------------------------------------------------------------------
  // outputs straight from flip-flops
  // ----------------------------------------------------------------------
  assign MOD_CLK_A = acc[0][cafc_pkg::NCO_W-1];
  assign MOD_CLK_B = acc[1][cafc_pkg::NCO_W-1];
  assign DECIMATION_RATE_A = decimation_rates[cafc_pkg::HALF_W-1:0];
  assign DECIMATION_RATE_B =
    decimation_rates[2*cafc_pkg::HALF_W-1:cafc_pkg::HALF_W];
  assign DEC_STROBE_A = dec_strobe[0];
  assign DEC_STROBE_B = dec_strobe[1];
  assign RAW_CURRENT_ZERO = raw[0];
  assign RAW_CURRENT_ONE = raw[1];

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  a_nco_wrap_b: assert property ( // RQ1
    incr[1] == 32'h4000_0000 && $stable(incr[1]) && !MOD_CLK_B
    |=> MOD_CLK_B ##1 !MOD_CLK_B)
    else $error("half-rate modulator clock b not toggling");

  a_dec_pwm_a: assert property ( // RQ3
    DECIMATION_RATE_A == 16'h0000 && PWM_SYNC |=> DEC_STROBE_A)
    else $error("pwm synchronous strobe missing");

  a_dec_only_edge: assert property ( // RQ4
    DECIMATION_RATE_B != 16'h0000 && !gen_chan[1].mod_rise
    |=> !DEC_STROBE_B)
    else $error("decimation strobe without modulator edge");

  a_raw_ext0: assert property ( // RQ7
    current_source_select[7:0] == cafc_pkg::SRC_EXT0
    |=> RAW_CURRENT_ZERO == $past(external_value[15:0]))
    else $error("raw current 0 not from external value 0");

  a_raw_ds0_one: assert property ( // RQ9
    current_source_select[15:8] == cafc_pkg::SRC_DS0
    |=> RAW_CURRENT_ONE == $past(DELTASIGMA_CHANNEL0_VALUE))
    else $error("raw current 1 not from delta-sigma 0");

  a_phase_u_map: assert property ( // RQ10
    current_source_select[25:24] == cafc_pkg::PH_I1
    |=> PHASE_U_CURRENT == $past(cur[1]))
    else $error("phase u not mapped to current 1");

  a_phase_w_sum: assert property ( // RQ8
    current_source_select[29:28] == cafc_pkg::PH_I2 &&
    cur[0] == 16'sh1E00 && cur[1] == 16'sh0C00
    |=> PHASE_W_CURRENT == -16'sh2A00)
    else $error("phase w not the negated current sum");

  a_cal1_readback: assert property ( // RQ5
    REG_WR && REG_ADDR == cafc_pkg::ADDR_CAL1 ##1
    (!REG_WR && REG_ADDR == cafc_pkg::ADDR_CAL1)
    |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("current1 calibration readback wrong");

  a_cal0_offset: assert property ( // RQ6
    REG_WR && REG_ADDR == cafc_pkg::ADDR_CAL0
    |=> gen_chan[0].cal_bus.offset == $past(REG_WDATA[15:0]))
    else $error("current0 offset not applied");

endmodule
